// ---- hdl/pcs_sequencer.sv ----
// pcs_sequencer: program counter, return stack and special registers.
// assumes the decoder drives one instr_exec pulse per instruction and
// register strobes on the plain port, all in the clk domain.
//
// Strobed register access was decided locally.
`timescale 1ns/100ps
module pcs_sequencer (
  input  wire logic                          clk,
  input  wire logic                          reset,
  input  wire logic                          mclr_rst,
  input  wire logic                          wdt_rst,
  input  wire logic                          wake_rst,
  input  wire logic                          bor_rst,
  input  wire logic                          instr_exec,
  input  wire logic                          op_jump,
  input  wire logic                          op_call,
  input  wire logic                          op_return_with_literal,
  input  wire logic [pcs_pkg::IW-1:0]        instr_word,
  input  wire logic                          alu_flags_we,
  input  wire logic [pcs_pkg::ST_ALU_W-1:0]  alu_flags,
  input  wire logic                          timer_tick,
  input  wire logic [pcs_pkg::AW-1:0]        reg_addr,
  input  wire logic [pcs_pkg::DW-1:0]        reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [pcs_pkg::DW-1:0]        reg_rdata,
  input  wire logic                          dir_wr,
  input  wire logic                          dir_sel,
  input  wire logic                          opt_wr,
  input  wire logic                          opt2_wr,
  input  wire logic [pcs_pkg::LO_PORT_W-1:0] lo_port_in,
  output logic      [pcs_pkg::LO_PORT_W-1:0] lo_port_out,
  output logic      [pcs_pkg::LO_PORT_W-1:0] lo_port_oe_n,
  input  wire logic [pcs_pkg::DW-1:0]        hi_port_in,
  output logic      [pcs_pkg::DW-1:0]        hi_port_out,
  output logic      [pcs_pkg::DW-1:0]        hi_port_oe_n,
  output logic      [pcs_pkg::PC_W-1:0]      pc,
  output logic                               acc_load,
  output logic      [pcs_pkg::DW-1:0]        acc_data,
  output logic      [pcs_pkg::CFG_W-1:0]     prescale_cfg,
  output logic      [pcs_pkg::CFG_W-1:0]     ext_cfg
);

  localparam int PC_W  = pcs_pkg::PC_W;
  localparam int DW    = pcs_pkg::DW;
  localparam int AW    = pcs_pkg::AW;
  localparam int LPW   = pcs_pkg::LO_PORT_W;
  localparam int STK_W = pcs_pkg::STK_W;

  // ---------------------------------------------------------------
  // reset classification
  // ---------------------------------------------------------------
  pcs_pkg::pcs_rst_kind_type rst_kind;
  logic                      any_rst;

  // cold wins over warm, warm over wake
  always_comb begin
    if (reset || bor_rst) begin
      rst_kind = pcs_pkg::PCS_RST_COLD;
    end else if (mclr_rst || wdt_rst) begin
      rst_kind = pcs_pkg::PCS_RST_WARM;
    end else if (wake_rst) begin
      rst_kind = pcs_pkg::PCS_RST_WAKE;
    end else begin
      rst_kind = pcs_pkg::PCS_RST_NONE;
    end
  end

  assign any_rst = (rst_kind != pcs_pkg::PCS_RST_NONE);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [PC_W-1:0]           pc_r;
  logic [DW-1:0]             status_r;
  logic [DW-1:0]             ptr_r;
  logic [DW-1:0]             timer_r;
  logic [LPW-1:0]            lo_latch_r;
  logic [DW-1:0]             hi_latch_r;
  logic [LPW-1:0]            lo_dir_r;
  logic [DW-1:0]             hi_dir_r;
  logic [pcs_pkg::CFG_W-1:0] opt_r;
  logic [pcs_pkg::CFG_W-1:0] opt2_r;
  logic [DW-1:0]             rdata_r;
  logic                      acc_load_r;
  logic [DW-1:0]             acc_data_r;

  // ---------------------------------------------------------------
  // address resolution
  // ---------------------------------------------------------------
  logic [AW-1:0] eff_addr;
  logic          wr_hit;
  logic [DW-1:0] ram_rdata;

  assign eff_addr = (reg_addr == pcs_pkg::ADDR_INDIRECT) ? ptr_r[AW-1:0]
                                                         : reg_addr;

  // writes aimed at the indirect port land on the pointed address;
  // a pointer of zero leaves nothing to write, and a reset cycle drops it
  assign wr_hit = reg_wr && !any_rst && (eff_addr != pcs_pkg::ADDR_INDIRECT);

  // ---------------------------------------------------------------
  // file register storage
  // ---------------------------------------------------------------
  pcs_data_ram #(
    .AW (AW),
    .DW (DW),
    .LO (32'(pcs_pkg::ADDR_RAM_LO))
  ) u_ram (
    .clk   (clk),
    .we    (wr_hit && (eff_addr >= pcs_pkg::ADDR_RAM_LO)),
    .waddr (eff_addr),
    .wdata (reg_wdata),
    .raddr (eff_addr),
    .rdata (ram_rdata)
  );

  // ---------------------------------------------------------------
  // return stack
  // ---------------------------------------------------------------
  logic [PC_W-1:0]  pc_inc;
  logic [STK_W-1:0] stk_top;
  logic             do_call;
  logic             do_ret;

  assign pc_inc  = pc_r + PC_W'(1);
  assign do_call = instr_exec && op_call && !any_rst;
  assign do_ret  = instr_exec && op_return_with_literal && !any_rst;

  // no overflow flag, excess push just drops
  pcs_ret_stack #(
    .W     (STK_W),
    .DEPTH (pcs_pkg::STK_DEPTH)
  ) u_stack (
    .clk       (clk),
    .push      (do_call),
    .pop       (do_ret),
    .push_data (STK_W'(pc_inc)),
    .top       (stk_top)
  );

  // ---------------------------------------------------------------
  // program counter
  // ---------------------------------------------------------------
  logic [PC_W-1:0] pc_nxt;
  logic            pcl_wr;

  // move, add, bit-set all arrive as writes here
  assign pcl_wr = wr_hit && (eff_addr == pcs_pkg::ADDR_PC_LOW);

  // a low byte write outranks the sequencing of the same cycle
  always_comb begin
    pc_nxt = pc_r;
    if (pcl_wr) begin
      // low byte write clears bit 8
      pc_nxt = {1'b0, reg_wdata};
    end else if (instr_exec) begin
      if (op_jump) begin
        pc_nxt = instr_word[PC_W-1:0];
      end else if (op_call) begin
        pc_nxt = {1'b0, instr_word[DW-1:0]};
      end else if (op_return_with_literal) begin
        pc_nxt = stk_top[PC_W-1:0];
      end else begin
        pc_nxt = pc_inc;
      end
    end
  end

  // reset vector, low byte all ones
  always_ff @(posedge clk) begin
    if (any_rst) begin
      pc_r <= pcs_pkg::PC_RESET;
    end else begin
      pc_r <= pc_nxt;
    end
  end

  assign pc = pc_r;

  // ---------------------------------------------------------------
  // accumulator load
  // ---------------------------------------------------------------
  // literal to accumulator
  always_ff @(posedge clk) begin
    if (rst_kind == pcs_pkg::PCS_RST_COLD) begin
      acc_load_r <= 1'b0;
      acc_data_r <= '0;
    end else begin
      acc_load_r <= do_ret;
      if (do_ret) begin
        acc_data_r <= instr_word[DW-1:0];
      end
    end
  end

  assign acc_load = acc_load_r;
  assign acc_data = acc_data_r;

  // ---------------------------------------------------------------
  // status register
  // ---------------------------------------------------------------
  // status bit positions, declared before the process that uses them
  localparam int ST_WAKE_B = pcs_pkg::ST_WAKE;
  localparam int ST_PGH_B  = pcs_pkg::ST_PAGE_HI;
  localparam int ST_PGL_B  = pcs_pkg::ST_PAGE_LO;
  localparam int ST_TO_B   = pcs_pkg::ST_TO;
  localparam int ALU_HI    = pcs_pkg::ST_ALU_W - 1;

  // timeout and powerdown are read only to software
  always_ff @(posedge clk) begin
    case (rst_kind)
      pcs_pkg::PCS_RST_COLD: begin
        status_r <= pcs_pkg::STATUS_COLD;
      end
      pcs_pkg::PCS_RST_WARM: begin
        status_r[ST_WAKE_B]    <= 1'b1;
        status_r[ST_PGH_B]     <= 1'b0;
        status_r[ST_PGL_B]     <= 1'b0;
        // watchdog expiry is the one that drops timeout
        if (wdt_rst && !mclr_rst) begin
          status_r[ST_TO_B] <= 1'b0;
        end
      end
      pcs_pkg::PCS_RST_WAKE: begin
        status_r[ST_WAKE_B] <= 1'b0;
        status_r[ST_PGH_B]  <= 1'b0;
        status_r[ST_PGL_B]  <= 1'b0;
      end
      default: begin
        if (wr_hit && (eff_addr == pcs_pkg::ADDR_STATUS)) begin
          status_r[ST_WAKE_B:ST_PGL_B] <= reg_wdata[ST_WAKE_B:ST_PGL_B];
          status_r[ALU_HI:0]           <= reg_wdata[ALU_HI:0];
        end else if (alu_flags_we) begin
          status_r[ALU_HI:0] <= alu_flags;
        end
      end
    endcase
  end

  // ---------------------------------------------------------------
  // indirect pointer
  // ---------------------------------------------------------------
  // top bits forced to ones; low bits cleared only on cold reset
  // to keep simulation free of unknowns
  always_ff @(posedge clk) begin
    if (rst_kind == pcs_pkg::PCS_RST_COLD) begin
      ptr_r <= {pcs_pkg::PTR_TOP_ONES, 5'h00};
    end else if (any_rst) begin
      ptr_r[DW-1:AW] <= pcs_pkg::PTR_TOP_ONES;
    end else if (wr_hit && (eff_addr == pcs_pkg::ADDR_POINTER)) begin
      ptr_r <= {pcs_pkg::PTR_TOP_ONES, reg_wdata[AW-1:0]};
    end
  end

  // ---------------------------------------------------------------
  // timer count
  // ---------------------------------------------------------------
  // cleared only by cold resets; prescaler itself lives elsewhere
  always_ff @(posedge clk) begin
    if (rst_kind == pcs_pkg::PCS_RST_COLD) begin
      timer_r <= '0;
    end else if (any_rst) begin
      timer_r <= timer_r;
    end else if (wr_hit && (eff_addr == pcs_pkg::ADDR_TIMER)) begin
      timer_r <= reg_wdata;
    end else if (timer_tick) begin
      timer_r <= timer_r + DW'(1);
    end
  end

  // ---------------------------------------------------------------
  // port output latches
  // ---------------------------------------------------------------
  // latches are unknown on real parts; cleared on cold reset here
  always_ff @(posedge clk) begin
    if (rst_kind == pcs_pkg::PCS_RST_COLD) begin
      lo_latch_r <= '0;
      hi_latch_r <= '0;
    end else if (!any_rst && wr_hit) begin
      if (eff_addr == pcs_pkg::ADDR_LO_PORT) begin
        lo_latch_r <= reg_wdata[LPW-1:0];
      end else if (eff_addr == pcs_pkg::ADDR_HI_PORT) begin
        hi_latch_r <= reg_wdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // direction latches
  // ---------------------------------------------------------------
  // all set on reset, pins float
  always_ff @(posedge clk) begin
    if (any_rst) begin
      lo_dir_r <= pcs_pkg::DIR_RESET[LPW-1:0];
      hi_dir_r <= pcs_pkg::DIR_RESET;
    end else if (dir_wr) begin
      if (dir_sel) begin
        hi_dir_r <= reg_wdata;
      end else begin
        lo_dir_r <= reg_wdata[LPW-1:0];
      end
    end
  end

  // a set direction bit releases the pin
  assign lo_port_out  = lo_latch_r;
  assign lo_port_oe_n = lo_dir_r;
  assign hi_port_out  = hi_latch_r;
  assign hi_port_oe_n = hi_dir_r;

  // ---------------------------------------------------------------
  // configuration latches
  // ---------------------------------------------------------------
  // prescale setup returns to all ones on every reset
  always_ff @(posedge clk) begin
    if (any_rst) begin
      opt_r <= pcs_pkg::CFG_RESET;
    end else if (opt_wr) begin
      opt_r <= reg_wdata[pcs_pkg::CFG_W-1:0];
    end
  end

  // extended setup only survives warm and wake resets
  always_ff @(posedge clk) begin
    if (rst_kind == pcs_pkg::PCS_RST_COLD) begin
      opt2_r <= pcs_pkg::CFG_RESET;
    end else if (!any_rst && opt2_wr) begin
      opt2_r <= reg_wdata[pcs_pkg::CFG_W-1:0];
    end
  end

  assign prescale_cfg = opt_r;
  assign ext_cfg      = opt2_r;

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  logic [DW-1:0] rd_val;

  // ports read the pins, not the latches
  always_comb begin
    rd_val = '0;
    if (eff_addr == pcs_pkg::ADDR_TIMER) begin
      rd_val = timer_r;
    end else if (eff_addr == pcs_pkg::ADDR_PC_LOW) begin
      // only the low byte is visible
      rd_val = pc_r[DW-1:0];
    end else if (eff_addr == pcs_pkg::ADDR_STATUS) begin
      rd_val = status_r;
    end else if (eff_addr == pcs_pkg::ADDR_POINTER) begin
      rd_val = ptr_r;
    end else if (eff_addr == pcs_pkg::ADDR_LO_PORT) begin
      rd_val = {{(DW-LPW){1'b0}}, lo_port_in};
    end else if (eff_addr == pcs_pkg::ADDR_HI_PORT) begin
      rd_val = hi_port_in;
    end else if (eff_addr >= pcs_pkg::ADDR_RAM_LO) begin
      rd_val = ram_rdata;
    end
  end

  // data stands for exactly the cycle after the strobe
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_r <= '0;
    end else if (reg_rd) begin
      rdata_r <= rd_val;
    end else begin
      rdata_r <= '0;
    end
  end

  assign reg_rdata = rdata_r;

endmodule // pcs_sequencer

// ---- hdl/pcs_pkg.sv ----
// pcs_pkg: constants shared by the program counter and stack block.
// assumes a single core clock; all offsets are data-memory addresses.
package pcs_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int PC_W      = 9;   // 512-word program page
  localparam int STK_W     = 12;  // return stack level width
  localparam int STK_DEPTH = 4;
  localparam int DW        = 8;
  localparam int AW        = 5;
  localparam int IW        = 12;  // instruction word
  localparam int LO_PORT_W = 4;
  localparam int CFG_W     = 6;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [AW-1:0] ADDR_INDIRECT = 5'h00;
  localparam logic [AW-1:0] ADDR_TIMER    = 5'h01;
  localparam logic [AW-1:0] ADDR_PC_LOW   = 5'h02;
  localparam logic [AW-1:0] ADDR_STATUS   = 5'h03;
  localparam logic [AW-1:0] ADDR_POINTER  = 5'h04;
  localparam logic [AW-1:0] ADDR_LO_PORT  = 5'h05;
  localparam logic [AW-1:0] ADDR_HI_PORT  = 5'h06;
  localparam logic [AW-1:0] ADDR_RAM_LO   = 5'h07;

  // ---------------------------------------------------------------
  // status field positions
  // ---------------------------------------------------------------
  localparam int ST_WAKE    = 7;
  localparam int ST_PAGE_HI = 6;
  localparam int ST_PAGE_LO = 5;
  localparam int ST_TO      = 4;
  localparam int ST_PD      = 3;
  localparam int ST_ALU_W   = 3;  // zero, digit carry, carry

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [PC_W-1:0]  PC_RESET     = 9'h1ff;
  localparam logic [DW-1:0]    STATUS_COLD  = 8'h98;
  localparam logic [2:0]       PTR_TOP_ONES = 3'h7;
  localparam logic [DW-1:0]    DIR_RESET    = 8'hff;
  localparam logic [CFG_W-1:0] CFG_RESET    = 6'h3f;

  // kind of reset being applied in this cycle
  typedef enum logic [1:0] {
    PCS_RST_NONE,
    PCS_RST_COLD,
    PCS_RST_WARM,
    PCS_RST_WAKE
  } pcs_rst_kind_type;

endpackage

// ---- hdl/pcs_ret_stack.sv ----
// pcs_ret_stack: four-level return address shift stack.
// assumes push and pop are never asserted together.
`timescale 1ns/100ps
module pcs_ret_stack #(
  parameter int W     = 12,
  parameter int DEPTH = 4
) (
  input  wire logic         clk,
  input  wire logic         push,
  input  wire logic         pop,
  input  wire logic [W-1:0] push_data,
  output logic      [W-1:0] top
);

  logic [W-1:0] lvl_r [DEPTH];

  // ---------------------------------------------------------------
  // levels
  // ---------------------------------------------------------------
  // no reset here
  // no reset on purpose: stack survives every reset kind
  for (genvar i = 0; i < DEPTH; i++) begin : g_lvl
    if (i == 0) begin : g_first
      always_ff @(posedge clk) begin
        if (push) begin
          lvl_r[i] <= push_data;
        end else if (pop) begin
          lvl_r[i] <= lvl_r[i+1];
        end
      end
    end else if (i == DEPTH-1) begin : g_last
      always_ff @(posedge clk) begin
        if (push) begin
          lvl_r[i] <= lvl_r[i-1];
        end
      end
    end else begin : g_mid
      always_ff @(posedge clk) begin
        if (push) begin
          lvl_r[i] <= lvl_r[i-1];
        end else if (pop) begin
          lvl_r[i] <= lvl_r[i+1];
        end
      end
    end
  end

  assign top = lvl_r[0];

endmodule // pcs_ret_stack

// ---- hdl/pcs_data_ram.sv ----
// pcs_data_ram: general purpose file registers in flip-flops.
// assumes the caller only writes addresses at or above LO.
`timescale 1ns/100ps
module pcs_data_ram #(
  parameter int AW = 5,
  parameter int DW = 8,
  parameter int LO = 7
) (
  input  wire logic          clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata
);

  localparam int N = (1 << AW) - LO;

  logic [DW-1:0] mem_r [N];

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  // contents are left alone by reset, like real file registers
  for (genvar i = 0; i < N; i++) begin : g_ent
    always_ff @(posedge clk) begin
      if (we && (waddr == AW'(i + LO))) begin
        mem_r[i] <= wdata;
      end
    end
  end

  // read mux; low addresses belong to the caller
  always_comb begin
    rdata = '0;
    if (raddr >= AW'(LO)) begin
      rdata = mem_r[raddr - AW'(LO)];
    end
  end

endmodule // pcs_data_ram

// ---- tb/pcs_sequencer_asserts.sv ----
// pcs_sequencer_asserts: port checks on pc, return literal load and reads.
// assumes bind into pcs_sequencer; one clock, synchronous resets.
`timescale 1ns/100ps
module pcs_sequencer_asserts (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        mclr_rst,
  input wire logic        wdt_rst,
  input wire logic        wake_rst,
  input wire logic        bor_rst,
  input wire logic        instr_exec,
  input wire logic        op_jump,
  input wire logic        op_call,
  input wire logic        op_return_with_literal,
  input wire logic [11:0] instr_word,
  input wire logic [4:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic [3:0]  lo_port_oe_n,
  input wire logic [7:0]  hi_port_oe_n,
  input wire logic [8:0]  pc,
  input wire logic        acc_load,
  input wire logic [7:0]  acc_data
);
  logic any_rst;
  logic pcl_wr;
  logic plain;
  // ---------------------------------------------
  // helpers
  // ---------------------------------------------
  // other resets also mask write and execute strobes, so causes exclude them
  assign any_rst = mclr_rst | wdt_rst | wake_rst | bor_rst;
  assign pcl_wr  = reg_wr && reg_addr == pcs_pkg::ADDR_PC_LOW;
  assign plain   = instr_exec && !any_rst && !pcl_wr;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  pc_vector_a: assert property (any_rst |=> pc == pcs_pkg::PC_RESET)
    else $error("pc missed reset vector");
  oe_release_a: assert property (any_rst |=> &lo_port_oe_n && &hi_port_oe_n)
    else $error("direction latches not set");
  pc_step_a: assert property (
    plain && !op_jump && !op_call && !op_return_with_literal |=> pc == $past(pc) + 9'h001)
    else $error("pc did not step");
  jump_load_a: assert property (
    plain && op_jump |=> pc == $past(instr_word[8:0]))
    else $error("jump target wrong");
  call_load_a: assert property (
    plain && op_call |=> pc == {1'h0, $past(instr_word[7:0])})
    else $error("call target wrong");
  pcl_write_a: assert property (
    pcl_wr && !any_rst |=> pc == {1'h0, $past(reg_wdata)})
    else $error("low byte write wrong");
  ret_literal_a: assert property (
    plain && op_return_with_literal |-> ##1 acc_load && acc_data == $past(instr_word[7:0]))
    else $error("literal not loaded");
  acc_pulse_a: assert property (
    acc_load |-> $past(instr_exec && op_return_with_literal && !any_rst))
    else $error("stray accumulator load");
  pcl_read_a: assert property (
    reg_rd && reg_addr == pcs_pkg::ADDR_PC_LOW && !instr_exec && !any_rst
    |=> reg_rdata == $past(pc[7:0]))
    else $error("low byte read wrong");
  ptr_ones_a: assert property (
    reg_rd && reg_addr == pcs_pkg::ADDR_POINTER && !any_rst |=> reg_rdata[7:5] == 3'h7)
    else $error("pointer top bits not ones");
  port_upper_a: assert property (
    reg_rd && reg_addr == pcs_pkg::ADDR_LO_PORT && !any_rst |=> reg_rdata[7:4] == 4'h0)
    else $error("port upper bits not zero");
endmodule // pcs_sequencer_asserts

bind pcs_sequencer pcs_sequencer_asserts i_pcs_chk (
  .clk(clk), .reset(reset), .mclr_rst(mclr_rst), .wdt_rst(wdt_rst),
  .wake_rst(wake_rst), .bor_rst(bor_rst), .instr_exec(instr_exec),
  .op_jump(op_jump), .op_call(op_call), .op_return_with_literal(op_return_with_literal), .instr_word(instr_word),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .lo_port_oe_n(lo_port_oe_n), .hi_port_oe_n(hi_port_oe_n),
  .pc(pc), .acc_load(acc_load), .acc_data(acc_data));

// ---- tb/pcs_sequencer_tb.sv ----
// pcs_sequencer_tb: self-checking bench with a pc and stack model.
// assumes pcs_pkg and the checker compiled first; clk at 50 MHz.
`timescale 1ns/100ps
module pcs_sequencer_tb;
  logic        clk = 1'h0;
  logic        reset = 1'h1;
  logic [3:0]  rst_k = 4'h0;  // mclr, wdt, wake, brown-out
  logic        instr_exec = 1'h0;
  logic [2:0]  op = 3'h0;     // jump, call, return
  logic [11:0] instr_word = 12'h000;
  logic [4:0]  reg_addr = 5'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'h0;
  logic        reg_rd = 1'h0;
  logic        timer_tick = 1'h0;
  logic        dir_wr = 1'h0;
  logic        dir_sel = 1'h0;
  logic [3:0]  lo_port_in = 4'h0;
  logic [7:0]  reg_rdata;
  logic [3:0]  lo_port_oe_n;
  logic [7:0]  hi_port_oe_n;
  logic [3:0]  lo_port_out;
  logic [7:0]  hi_port_out;
  logic [5:0]  prescale_cfg;
  logic [5:0]  ext_cfg;
  logic [8:0]  pc;
  logic        acc_load;
  logic [7:0]  acc_data;
  logic [7:0]  d;
  int          num_errors = 0;
  int          checks_done = 0;
  int          pcm = 32'h1ff;
  int          stk[$] = '{0, 0, 0, 0};

  always #10 clk = ~clk;

  pcs_sequencer i_pcs_sequencer (
    .clk(clk), .reset(reset), .mclr_rst(rst_k[0]), .wdt_rst(rst_k[1]),
    .wake_rst(rst_k[2]), .bor_rst(rst_k[3]), .instr_exec(instr_exec),
    .op_jump(op[0]), .op_call(op[1]), .op_return_with_literal(op[2]), .instr_word(instr_word),
    .alu_flags_we(1'h0), .alu_flags(3'h0), .timer_tick(timer_tick),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .dir_wr(dir_wr), .dir_sel(dir_sel), .opt_wr(1'h0),
    .opt2_wr(1'h0), .lo_port_in(lo_port_in), .lo_port_out(lo_port_out),
    .lo_port_oe_n(lo_port_oe_n), .hi_port_in(8'h5a), .hi_port_out(hi_port_out),
    .hi_port_oe_n(hi_port_oe_n), .pc(pc), .acc_load(acc_load), .acc_data(acc_data),
    .prescale_cfg(prescale_cfg), .ext_cfg(ext_cfg));

  // ---------------------------------------------
  // tasks
  // ---------------------------------------------
  task automatic chk(input string s, input int e, input logic [15:0] g);
    checks_done++;
    if (g !== 16'(e)) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", s, 16'(e), g);
    end
  endtask

  task automatic conclude;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'h0;
    #1;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [4:0] a, output logic [7:0] v);
    @(posedge clk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'h0;
    #1;
    v = reg_rdata;
  endtask

  task automatic exec(input logic [2:0] k, input logic [11:0] w);
    @(posedge clk);
    instr_exec <= 1'h1;
    op <= k;
    instr_word <= w;
    @(posedge clk);
    instr_exec <= 1'h0;
    op <= 3'h0;
    #1;
    // shift stack model, level 4 sticks
    if (k[0]) begin
      pcm = w[8:0];
    end else if (k[1]) begin
      stk = {pcm + 1, stk[0:2]};
      pcm = w[7:0];
    end else if (k[2]) begin
      pcm = stk[0];
      stk = {stk[1:3], stk[3]};
    end else begin
      pcm = (pcm + 1) % 512;
    end
    chk("pc", pcm, pc);
    chk("acc_load", k[2], acc_load);
    if (k[2]) chk("acc_data", w[7:0], acc_data);
  endtask

  task automatic after_rst;
    pcm = 32'h1ff;
    chk("pc_rst", pcm, pc);
    chk("oe_rst", 32'hfff, {lo_port_oe_n, hi_port_oe_n});
    chk("cfg_rst", 32'h3f, prescale_cfg);
    rd(5'h03, d);
    chk("pages", 0, d[6:5]);
    rd(5'h04, d);
    chk("ptr_top", 7, d[7:5]);
  endtask

  // pages and one port driven first, so the reset has work to undo
  task automatic rst_kind(input int k);
    wr(5'h03, 8'h60);
    @(posedge clk);
    dir_wr <= 1'h1;
    dir_sel <= k[0];
    reg_wdata <= 8'h00;
    @(posedge clk);
    dir_wr <= 1'h0;
    #1;
    chk("oe_wr", 0, k[0] ? hi_port_oe_n : lo_port_oe_n);
    @(posedge clk);
    rst_k[k] <= 1'h1;
    @(posedge clk);
    rst_k <= 4'h0;
    #1;
    after_rst();
  endtask

  // ---------------------------------------------
  // main sequence
  // ---------------------------------------------
  initial begin
    void'($urandom(32'hcf06));
    repeat (6) @(posedge clk);
    reset <= 1'h0;
    #1;
    after_rst();
    @(posedge clk);
    lo_port_in <= 4'($urandom);
    rd(5'h05, d);
    chk("lo_port", {4'h0, lo_port_in}, d);
    chk("ext_cfg", 32'h3f, ext_cfg);
    // output latches are separate from the pins that reads return
    wr(5'h05, 8'hff);
    wr(5'h06, 8'ha5);
    chk("lo_out", 32'hf, lo_port_out);
    chk("hi_out", 32'ha5, hi_port_out);
    rd(5'h06, d);
    chk("hi_port", 32'h5a, d);
    repeat (6) begin
      exec(3'h1, 12'($urandom));
      exec(3'h0, 12'h000);
    end
    // five calls overflow; every reset kind leaves the stack alone
    exec(3'h1, 12'h0f0);
    repeat (5) exec(3'h2, 12'($urandom));
    for (int k = 0; k < 4; k++) rst_kind(k);
    repeat (6) exec(3'h4, 12'($urandom));
    // timer counts five ticks, then survives a master clear
    @(posedge clk);
    timer_tick <= 1'h1;
    repeat (5) @(posedge clk);
    timer_tick <= 1'h0;
    rd(5'h01, d);
    chk("timer", 5, d);
    rst_kind(0);
    rd(5'h01, d);
    chk("timer_kept", 5, d);
    repeat (4) begin
      d = 8'($urandom);
      wr(5'h02, d);
      pcm = d;
      chk("pc_wr", pcm, pc);
      rd(5'h02, d);
      chk("pcl", pcm, d);
    end
    wr(5'h04, 8'h12);
    wr(5'h00, 8'ha5);
    rd(5'h12, d);
    chk("ind_wr", 32'ha5, d);
    wr(5'h13, 8'h3c);
    wr(5'h04, 8'h13);
    rd(5'h00, d);
    chk("ind_rd", 32'h3c, d);
    conclude();
  end

  // hang guard
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    conclude();
  end
endmodule // pcs_sequencer_tb
